//--- rtl/dsp_core_datapath.sv
/*
  Dual-element SIMD datapath: register files, ALU/multiplier with interlock,
  circular address generators, exchange and universal registers, timer,
  event latch, conflict cache, branch predictor, format decode.
  Assumes sequencer and L1 buses on core_clk; all inputs synchronous.
*/
`timescale 1ns/100ps
`include "dsp_core_regs.svh"

////////////////////////////////////////////////////////////////////////////////
module dsp_circ_addr_gen (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic bankSel,
  input wire dsp_core_pkg::ag_cmd_t cmd,
  output logic [31:0] addr
);
  logic [31:0] idx_ff [`AG_SLOTS];
  logic [31:0] base_ff [`AG_SLOTS];
  logic [31:0] len_ff [`AG_SLOTS];
  logic [31:0] addr_ff, nxt_addr, sum, lim, nxtIdx;
  logic [3:0] slot;

  always_comb begin
    slot = {bankSel, cmd.set};
    sum = idx_ff[slot] + cmd.modify;
    lim = base_ff[slot] + len_ff[slot];
    nxtIdx = sum;
    if (!cmd.modify[31] && sum >= lim) begin
      nxtIdx = sum - len_ff[slot];
    end else if (cmd.modify[31] && sum < base_ff[slot]) begin
      nxtIdx = sum + len_ff[slot];
    end
    nxt_addr = addr_ff;
    if (cmd.valid && !cmd.load) begin
      nxt_addr = idx_ff[slot];
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      addr_ff <= `RST_WORD32;
      for (int i = 0; i < `AG_SLOTS; i++) begin
        idx_ff[i] <= `RST_WORD32;
        base_ff[i] <= `RST_WORD32;
        len_ff[i] <= `RST_WORD32;
      end
    end else begin
      addr_ff <= nxt_addr;
      if (cmd.valid && cmd.load) begin
        idx_ff[slot] <= cmd.base;
        base_ff[slot] <= cmd.base;
        len_ff[slot] <= cmd.len;
      end else if (cmd.valid) begin
        idx_ff[slot] <= nxtIdx;
      end
    end
  end

  assign addr = addr_ff;

  AST_AG_WRAP: assert property (@(posedge core_clk) disable iff (!resetn)
    cmd.valid && !cmd.load && !cmd.modify[31] && cmd.modify < len_ff[slot]
    && idx_ff[slot] >= base_ff[slot] && idx_ff[slot] < lim
    |=> idx_ff[$past(slot)] >= base_ff[$past(slot)]
    && idx_ff[$past(slot)] < base_ff[$past(slot)] + len_ff[$past(slot)])
    else $error("Circular pointer left its buffer");
  CV_AG_WRAP: cover property (@(posedge core_clk) disable iff (!resetn)
    cmd.valid && !cmd.load && nxtIdx != sum);
endmodule

////////////////////////////////////////////////////////////////////////////////
module dsp_core_datapath (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic modeWe,
  input wire dsp_core_pkg::mode_t modeIn,
  input wire dsp_core_pkg::op_cmd_t opCmd,
  output logic opReady,
  output logic [39:0] resX,
  output logic [39:0] resY,
  output logic [39:0] mulResX,
  output logic [39:0] mulResY,
  input wire logic dmLoadValid,
  input wire logic [3:0] dmLoadDst,
  input wire logic [63:0] dmLoadData,
  input wire logic [7:0] dmLoadPar,
  input wire logic pmLoadValid,
  input wire logic [3:0] pmLoadDst,
  input wire logic [63:0] pmBusData,
  input wire logic [3:0] storeSrc,
  output logic [63:0] storeData,
  input wire dsp_core_pkg::px_src_t pxSrc,
  output logic [63:0] pxOut,
  input wire dsp_core_pkg::ag_cmd_t agCmd0,
  input wire dsp_core_pkg::ag_cmd_t agCmd1,
  output logic [31:0] agAddr0,
  output logic [31:0] agAddr1,
  input wire dsp_core_pkg::ub_cmd_t ubCmd,
  output logic [31:0] ubValue,
  output logic ubTestFlag,
  input wire logic fetchValid,
  input wire logic [23:0] fetchAddr,
  input wire logic [47:0] fetchWord,
  input wire logic pmConflict,
  output logic instrValid,
  output logic [47:0] instrWord,
  output logic [1:0] instrLen,
  output logic instrFromCache,
  input wire logic brValid,
  input wire logic [23:0] brPc,
  input wire logic [23:0] brTarget,
  input wire logic brTaken,
  output logic predTaken,
  output logic [23:0] predTarget,
  input wire logic convToWord,
  input wire logic [31:0] convIn,
  output logic [31:0] convOut,
  input wire logic exclLoad,
  input wire logic exclStore,
  input wire logic [31:0] exclAddr,
  output logic exclOk,
  input wire logic barrierReq,
  input wire logic busPending,
  output logic barrierStall,
  input wire logic [1:0] masterErr,
  input wire logic timerEn,
  input wire logic [31:0] timerPeriod,
  input wire logic [3:0] irqIn,
  input wire logic [7:0] irqMask,
  input wire logic [7:0] irqClr,
  output logic [7:0] irqPend,
  output logic irqReq
);
  function automatic logic [2:0] latOf(dsp_core_pkg::op_kind_t k);
    unique case (k)
      dsp_core_pkg::OP_FADD, dsp_core_pkg::OP_FMUL: latOf = `LAT_FP_DEP;
      dsp_core_pkg::OP_DADD: latOf = `LAT_DBL_ADD;
      dsp_core_pkg::OP_DMUL: latOf = `LAT_DBL_MUL;
      default: latOf = `LAT_ONE;
    endcase
  endfunction

  function automatic logic [39:0] aluFn(dsp_core_pkg::op_kind_t k, logic [39:0] a,
                                        logic [39:0] b);
    unique case (k)
      dsp_core_pkg::OP_SUB: aluFn = a - b;
      dsp_core_pkg::OP_AND: aluFn = a & b;
      dsp_core_pkg::OP_XOR: aluFn = a ^ b;
      dsp_core_pkg::OP_MUL, dsp_core_pkg::OP_FMUL, dsp_core_pkg::OP_DMUL: aluFn = a * b;
      default: aluFn = a + b;
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Mode, register files, interlocked execution
  dsp_core_pkg::mode_t mode_ff, nxt_mode;
  logic [39:0] rfX [32];
  logic [39:0] rfY [32];
  logic [39:0] mrX_ff [2];
  logic [39:0] mrY_ff [2];
  logic [39:0] aluX, aluY, mulX, mulY, dBX, dBY, resX_ff, resY_ff, nxt_resX, nxt_resY;
  logic [39:0] pendX_ff, pendY_ff, nxt_pendX, nxt_pendY;
  logic [4:0] rdA, rdB, wrA, wrB, pendDst_ff, nxt_pendDst;
  logic [2:0] lat, pendCnt_ff, nxt_pendCnt;
  logic pendYEn_ff, nxt_pendYEn, dep, issue, retire, weA, weB, weYA, weYB, weYL;
  dsp_core_pkg::op_kind_t kind;

  always_comb begin
    nxt_mode = modeWe ? modeIn : mode_ff;
    kind = opCmd.kind;
    rdA = {mode_ff.secData, opCmd.srcA};
    rdB = {mode_ff.secData, opCmd.srcB};
    wrA = {mode_ff.secData, opCmd.dst};
    aluX = aluFn(kind, rfX[rdA], rfX[rdB]);
    aluY = aluFn(kind, rfY[rdA], rfY[rdB]);
    mulX = rfX[rdA] * rfX[rdB];
    mulY = rfY[rdA] * rfY[rdB];
    lat = latOf(kind);
    dep = pendCnt_ff != 3'd0 && (rdA == pendDst_ff || rdB == pendDst_ff || wrA == pendDst_ff);
    opReady = pendCnt_ff == 3'd0 ||
      !(dep || lat != `LAT_ONE || kind == dsp_core_pkg::OP_MAC);
    issue = opCmd.valid && opReady && kind != dsp_core_pkg::OP_NOP;
    weA = issue && lat == `LAT_ONE;
    retire = pendCnt_ff == 3'd1;
    weB = retire || (weA && kind == dsp_core_pkg::OP_MAC);
    wrB = retire ? pendDst_ff : {mode_ff.secData, opCmd.dstMul};
    dBX = retire ? pendX_ff : mulX;
    dBY = retire ? pendY_ff : mulY;
    weYA = weA && mode_ff.secondEnable;
    weYB = retire ? pendYEn_ff : (weB && mode_ff.secondEnable);
    weYL = mode_ff.secondEnable && dmLoadValid;
    nxt_pendCnt = pendCnt_ff == 3'd0 ? 3'd0 : pendCnt_ff - 3'd1;
    nxt_pendDst = pendDst_ff;
    nxt_pendX = pendX_ff;
    nxt_pendY = pendY_ff;
    nxt_pendYEn = pendYEn_ff;
    if (issue && lat != `LAT_ONE) begin
      nxt_pendCnt = lat - 3'd1;
      nxt_pendDst = wrA;
      nxt_pendX = aluX;
      nxt_pendY = aluY;
      nxt_pendYEn = mode_ff.secondEnable;
    end
    nxt_resX = weA ? aluX : (retire ? pendX_ff : resX_ff);
    nxt_resY = weYA ? aluY : (retire && pendYEn_ff ? pendY_ff : resY_ff);
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      mode_ff <= '0;
      pendCnt_ff <= 3'd0;
      pendDst_ff <= 5'h00;
      pendX_ff <= 40'h0;
      pendY_ff <= 40'h0;
      pendYEn_ff <= 1'b0;
      resX_ff <= 40'h0;
      resY_ff <= 40'h0;
      mrX_ff <= '{40'h0, 40'h0};
      mrY_ff <= '{40'h0, 40'h0};
    end else begin
      mode_ff <= nxt_mode;
      pendCnt_ff <= nxt_pendCnt;
      pendDst_ff <= nxt_pendDst;
      pendX_ff <= nxt_pendX;
      pendY_ff <= nxt_pendY;
      pendYEn_ff <= nxt_pendYEn;
      resX_ff <= nxt_resX;
      resY_ff <= nxt_resY;
      if (weA && (kind == dsp_core_pkg::OP_MUL || kind == dsp_core_pkg::OP_MAC)) begin
        mrX_ff[mode_ff.secMul] <= mulX;
        if (mode_ff.secondEnable) begin
          mrY_ff[mode_ff.secMul] <= mulY;
        end
      end
    end
  end

  // Loads land in the high 32 bits of the 40-bit extended word
  always_ff @(posedge core_clk) begin
    if (pmLoadValid) begin
      rfX[{mode_ff.secData, pmLoadDst}] <= {pmBusData[31:0], 8'h00};
    end
    if (pmLoadValid && mode_ff.secondEnable) begin
      rfY[{mode_ff.secData, pmLoadDst}] <= {pmBusData[63:32], 8'h00};
    end
    if (dmLoadValid) begin
      rfX[{mode_ff.secData, dmLoadDst}] <= {dmLoadData[31:0], 8'h00};
    end
    if (weYL) begin
      rfY[{mode_ff.secData, dmLoadDst}] <= {dmLoadData[63:32], 8'h00};
    end
    if (weA) rfX[wrA] <= aluX;
    if (weYA) rfY[wrA] <= aluY;
    if (weB) rfX[wrB] <= dBX;
    if (weYB) rfY[wrB] <= dBY;
  end

  assign resX = resX_ff;
  assign resY = resY_ff;
  assign mulResX = mrX_ff[mode_ff.secMul];
  assign mulResY = mrY_ff[mode_ff.secMul];

  //////////////////////////////////////////////////////////////////////////////
  // Exchange, store, universal registers, address conversion, exclusives
  logic [63:0] px_ff, nxt_px, store_ff, nxt_store;
  logic [31:0] ub_ff [`UB_COUNT];
  logic [31:0] nxt_ub, conv_ff, nxt_conv, resvAddr_ff, nxt_resvAddr;
  logic ubTest_ff, nxt_ubTest, resv_ff, nxt_resv, exclOk_ff, nxt_exclOk;
  logic [4:0] rdS;

  always_comb begin
    rdS = {mode_ff.secData, storeSrc};
    nxt_store = {mode_ff.secondEnable ? rfY[rdS][39:8] : 32'h0, rfX[rdS][39:8]};
    unique case (pxSrc)
      dsp_core_pkg::PX_FROM_PM: nxt_px = pmBusData;
      dsp_core_pkg::PX_FROM_DM: nxt_px = dmLoadData;
      dsp_core_pkg::PX_FROM_RF: nxt_px = {24'h0, rfX[rdA]};
      default: nxt_px = px_ff;
    endcase
    nxt_ub = ub_ff[ubCmd.sel];
    nxt_ubTest = ubTest_ff;
    unique case (ubCmd.kind)
      dsp_core_pkg::UB_WRITE: nxt_ub = ubCmd.mask;
      dsp_core_pkg::UB_SET: nxt_ub = nxt_ub | ubCmd.mask;
      dsp_core_pkg::UB_CLR: nxt_ub = nxt_ub & ~ubCmd.mask;
      dsp_core_pkg::UB_TGL: nxt_ub = nxt_ub ^ ubCmd.mask;
      dsp_core_pkg::UB_XOR: nxt_ubTest = ubCmd.valid ? ~|(nxt_ub ^ ubCmd.mask) : ubTest_ff;
      default: nxt_ubTest = ubCmd.valid ? (nxt_ub & ubCmd.mask) == ubCmd.mask : ubTest_ff;
    endcase
    nxt_conv = convToWord ? {2'b00, convIn[31:2]} : {convIn[29:0], 2'b00};
    nxt_resv = resv_ff;
    nxt_resvAddr = resvAddr_ff;
    nxt_exclOk = exclOk_ff;
    if (exclStore) begin
      nxt_exclOk = resv_ff && resvAddr_ff == exclAddr;
      nxt_resv = 1'b0;
    end else if (exclLoad) begin
      nxt_resv = 1'b1;
      nxt_resvAddr = exclAddr;
    end
    barrierStall = barrierReq && busPending;
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      px_ff <= 64'h0;
      store_ff <= 64'h0;
      ub_ff <= '{`RST_WORD32, `RST_WORD32, `RST_WORD32, `RST_WORD32};
      ubTest_ff <= 1'b0;
      conv_ff <= `RST_WORD32;
      resv_ff <= 1'b0;
      resvAddr_ff <= `RST_WORD32;
      exclOk_ff <= 1'b0;
    end else begin
      px_ff <= nxt_px;
      store_ff <= nxt_store;
      if (ubCmd.valid && ubCmd.kind < dsp_core_pkg::UB_XOR) ub_ff[ubCmd.sel] <= nxt_ub;
      ubTest_ff <= nxt_ubTest;
      conv_ff <= nxt_conv;
      resv_ff <= nxt_resv;
      resvAddr_ff <= nxt_resvAddr;
      exclOk_ff <= nxt_exclOk;
    end
  end

  assign pxOut = px_ff;
  assign storeData = store_ff;
  assign ubValue = ub_ff[ubCmd.sel];
  assign ubTestFlag = ubTest_ff;
  assign convOut = conv_ff;
  assign exclOk = exclOk_ff;

  dsp_circ_addr_gen agPrimary (
    .core_clk(core_clk), .resetn(resetn), .bankSel(mode_ff.secAg), .cmd(agCmd0),
    .addr(agAddr0));
  dsp_circ_addr_gen agSecondary (
    .core_clk(core_clk), .resetn(resetn), .bankSel(mode_ff.secAg), .cmd(agCmd1),
    .addr(agAddr1));

  //////////////////////////////////////////////////////////////////////////////
  // Fetch decode, conflict cache, branch predictor
  logic [23:0] ccTag [`CC_ENTRIES];
  logic [47:0] ccData [`CC_ENTRIES];
  logic [`CC_ENTRIES-1:0] ccValid_ff, nxt_ccValid;
  logic [23:0] btsPc [`BTS_ENTRIES];
  logic [23:0] btsTgt [`BTS_ENTRIES];
  logic [1:0] btsCtr [`BTS_ENTRIES];
  logic [`BTS_ENTRIES-1:0] btsValid_ff, nxt_btsValid;
  logic [47:0] word, instr_ff, nxt_instr;
  logic [23:0] predTgt_ff, nxt_predTgt;
  logic [1:0] len_ff, nxt_len, ctrUp;
  logic [4:0] ci;
  logic [2:0] bi, ui;
  logic hit, useCache, fill, compact, illegal, iv_ff, fromCc_ff, predTk_ff, nxt_predTk;
  logic btsHit;

  always_comb begin
    ci = fetchAddr[4:0];
    hit = ccValid_ff[ci] && ccTag[ci] == fetchAddr;
    useCache = fetchValid && pmConflict && hit;
    fill = fetchValid && pmConflict && !hit;
    word = useCache ? ccData[ci] : fetchWord;
    compact = fetchAddr >= `COMPACT_BASE;
    nxt_len = compact ? (word[47] ? 2'd2 : 2'd1) : 2'd3;
    illegal = fetchValid && (compact ? word[47:32] == `ILLEGAL_COMPACT
                                     : word[47:45] == `ILLEGAL_FULL);
    nxt_instr = fetchValid ? word : instr_ff;
    nxt_ccValid = ccValid_ff;
    if (fill) nxt_ccValid[ci] = 1'b1;
    bi = fetchAddr[2:0];
    nxt_predTk = fetchValid && btsValid_ff[bi] && btsPc[bi] == fetchAddr && btsCtr[bi][1];
    nxt_predTgt = btsTgt[bi];
    ui = brPc[2:0];
    btsHit = btsValid_ff[ui] && btsPc[ui] == brPc;
    ctrUp = brTaken ? (btsCtr[ui] == 2'b11 ? 2'b11 : btsCtr[ui] + 2'b01)
                    : (btsCtr[ui] == 2'b00 ? 2'b00 : btsCtr[ui] - 2'b01);
    nxt_btsValid = btsValid_ff;
    if (brValid) nxt_btsValid[ui] = 1'b1;
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ccValid_ff <= '0;
      btsValid_ff <= '0;
      instr_ff <= 48'h0;
      len_ff <= 2'd0;
      iv_ff <= 1'b0;
      fromCc_ff <= 1'b0;
      predTk_ff <= 1'b0;
      predTgt_ff <= 24'h0;
    end else begin
      ccValid_ff <= nxt_ccValid;
      btsValid_ff <= nxt_btsValid;
      instr_ff <= nxt_instr;
      len_ff <= fetchValid ? nxt_len : len_ff;
      iv_ff <= fetchValid;
      fromCc_ff <= useCache;
      predTk_ff <= nxt_predTk;
      predTgt_ff <= nxt_predTgt;
    end
  end

  always_ff @(posedge core_clk) begin
    if (fill) begin
      ccTag[ci] <= fetchAddr;
      ccData[ci] <= fetchWord;
    end
    if (brValid) begin
      btsPc[ui] <= brPc;
      btsTgt[ui] <= brTaken ? brTarget : btsTgt[ui];
      btsCtr[ui] <= btsHit ? ctrUp : (brTaken ? 2'b10 : 2'b01);
    end
  end

  assign instrValid = iv_ff;
  assign instrWord = instr_ff;
  assign instrLen = len_ff;
  assign instrFromCache = fromCc_ff;
  assign predTaken = predTk_ff;
  assign predTarget = predTgt_ff;

  //////////////////////////////////////////////////////////////////////////////
  // Core timer and event latch
  logic [31:0] tmr_ff, nxt_tmr;
  logic [7:0] pend_ff, nxt_pend, events, parBad;
  logic tick;

  always_comb begin
    tick = timerEn && tmr_ff == `RST_WORD32;
    nxt_tmr = (!timerEn || tick) ? timerPeriod : tmr_ff - 32'h1;
    for (int b = 0; b < 8; b++) begin
      parBad[b] = (^dmLoadData[8*b +: 8]) ^ dmLoadPar[b];
    end
    events = {irqIn, |masterErr, illegal, dmLoadValid && |parBad, tick};
    nxt_pend = (pend_ff & ~irqClr) | events;
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      tmr_ff <= `RST_WORD32;
      pend_ff <= 8'h00;
    end else begin
      tmr_ff <= nxt_tmr;
      pend_ff <= nxt_pend;
    end
  end

  assign irqPend = pend_ff;
  assign irqReq = |(pend_ff & irqMask);

  //////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  AST_ONE_CYCLE: assert property (issue && kind == dsp_core_pkg::OP_ADD
    |=> resX == $past(aluX)) else $error("Add result late");
  AST_MAC_PAIR: assert property (issue && kind == dsp_core_pkg::OP_MAC
    |-> weA && weB && wrB[3:0] == opCmd.dstMul) else $error("Multifunction lost a half");
  AST_FP_DEP: assert property (issue && kind == dsp_core_pkg::OP_FADD
    |=> pendCnt_ff == 3'd1 ##1 pendCnt_ff == 3'd0) else $error("FP latency wrong");
  AST_DBL_MUL: assert property (issue && kind == dsp_core_pkg::OP_DMUL
    |=> pendCnt_ff == 3'd5 ##4 retire) else $error("Double multiply latency wrong");
  AST_INTERLOCK: assert property (opCmd.valid && dep |-> !opReady)
    else $error("Dependent op issued early");
  AST_TIMER: assert property (tick |=> tmr_ff == $past(timerPeriod))
    else $error("Timer reload wrong");
  AST_PEY_OFF: assert property (!mode_ff.secondEnable && !retire
    |-> !weYA && !weYB && !weYL) else $error("Second element written while off");
  AST_PARITY: assert property (dmLoadValid && |parBad
    |=> pend_ff[`IRQ_PARITY]) else $error("Parity error not flagged");
  AST_MASK: assert property ((pend_ff & irqMask) == 8'h00 |-> !irqReq)
    else $error("Masked interrupt raised");
  AST_CC_ONLY_CONFLICT: assert property (fetchValid && !pmConflict
    |=> !instrFromCache) else $error("Cache served without conflict");

  CV_STALL: cover property (opCmd.valid && dep ##1 opReady);
  CV_CC_HIT: cover property (useCache);
  CV_TICK: cover property (tick);
  CV_MAC_SIMD: cover property (issue && kind == dsp_core_pkg::OP_MAC && mode_ff.secondEnable);
endmodule

//--- rtl/dsp_core_regs.svh
/*
  Constants of the dual-element signal-processing datapath: widths, latencies,
  table sizes, event bit positions and reset values.
  Assumes inclusion by bare name from the datapath package users.
*/
// Function
// - Operand paths carry 32, 40 and 64-bit fixed and floating formats.
// - Multifunction op runs ALU and multiply together, in both elements in SIMD.
// - Independent operations finish in one core cycle. Here OP_FADD and OP_FMUL take two cycles even when independent.
// - Floating-point result feeding a dependent op takes two cycles.
// - Double-precision operations take two to six cycles.
// - Interlock stalls a dependent op exactly until the producer finishes.
// - Core-clocked timer raises periodic tick interrupts.
// - Each element has 32 registers: 16 primary, 16 secondary.
// - Primary banks active after reset; mode bits activate secondary banks.
// - First element always runs; second only when its enable bit is set.
// - SIMD address-generator transfers move two values per access.
// - Four universal registers do set, clear, toggle, test and XOR.
// - Exchange register moves data between 64-bit buses and 40-bit registers.
// - Two address generators hold 32 circular buffer sets, 16 per bank.
// - Pointer wrap costs no cycles; buffers start and end anywhere.
// - Format chosen by fetch address space: full 48-bit or compact 16/32-bit.
// - Four operands over two buses plus one cached instruction per cycle.
// - Only interrupts enabled in the mask are answered.
// - 32-entry conflict cache keeps only fetches colliding with bus data.
// - Branch predictor and target store cut branch delay.
// - Byte addressing with word-to-byte and byte-to-word conversion.
// - Byte parity errors and illegal opcodes raise core interrupts.
// - Failed external master accesses are detected and reported.
// - Memory barrier and exclusive access support data sharing.
`ifndef DSP_CORE_REGS_SVH
`define DSP_CORE_REGS_SVH
`define LAT_ONE 3'd1
`define LAT_FP_DEP 3'd2
`define LAT_DBL_ADD 3'd2
`define LAT_DBL_MUL 3'd6
`define AG_SLOTS 16
`define CC_ENTRIES 32
`define BTS_ENTRIES 8
`define UB_COUNT 4
`define IRQ_TIMER 0
`define IRQ_PARITY 1
`define IRQ_ILLEGAL 2
`define IRQ_BUSFAULT 3
`define COMPACT_BASE 24'h400000
`define ILLEGAL_FULL 3'h7
`define ILLEGAL_COMPACT 16'hffff
`define RST_WORD32 32'h00000000
`endif

//--- rtl/dsp_core_pkg.sv
/*
  Types of the signal-processing datapath: operation kinds and command carriers.
  Assumes nothing of its surroundings.
*/
package dsp_core_pkg;
  typedef enum logic [3:0] {OP_NOP = 4'h0, OP_ADD = 4'h1, OP_SUB = 4'h2, OP_AND = 4'h3,
    OP_XOR = 4'h4, OP_MUL = 4'h5, OP_MAC = 4'h6, OP_FADD = 4'h7, OP_FMUL = 4'h8,
    OP_DADD = 4'h9, OP_DMUL = 4'ha} op_kind_t;
  typedef struct packed {
    logic valid; op_kind_t kind; logic [3:0] dst; logic [3:0] dstMul;
    logic [3:0] srcA; logic [3:0] srcB;
  } op_cmd_t;
  typedef struct packed {
    logic secondEnable; logic secData; logic secAg; logic secMul;
  } mode_t;
  typedef enum logic [2:0] {UB_WRITE = 3'h0, UB_SET = 3'h1, UB_CLR = 3'h2, UB_TGL = 3'h3,
    UB_XOR = 3'h4, UB_TEST = 3'h5} ub_kind_t;
  typedef struct packed {
    logic valid; logic [1:0] sel; ub_kind_t kind; logic [31:0] mask;
  } ub_cmd_t;
  typedef struct packed {
    logic valid; logic load; logic [2:0] set; logic [31:0] base; logic [31:0] len;
    logic [31:0] modify;
  } ag_cmd_t;
  typedef enum logic [1:0] {PX_HOLD = 2'h0, PX_FROM_PM = 2'h1, PX_FROM_DM = 2'h2,
    PX_FROM_RF = 2'h3} px_src_t;
endpackage

//--- tb/l1_data_mem_model.sv
/*
  L1 data memory side: returns a load word with even parity per byte.
  Assumes requests change just after the core_clk rising edge.
*/
`timescale 1ns/100ps
module l1_data_mem_model (
  input wire logic core_clk,
  input wire logic ldReq,
  input wire logic [3:0] ldReg,
  input wire logic [31:0] ldWord,
  input wire logic ldBad,
  output logic dmLoadValid,
  output logic [3:0] dmLoadDst,
  output logic [63:0] dmLoadData,
  output logic [7:0] dmLoadPar
);
  logic [63:0] lastData_ff = 64'h0;
  always_ff @(posedge core_clk) begin
    if (ldReq) begin
      lastData_ff <= {32'h0, ldWord};
    end
  end
  // Released bus shows the inverse
  always_comb begin
    dmLoadValid = ldReq;
    dmLoadDst = ldReg;
    dmLoadData = ldReq ? {32'h0, ldWord} : ~lastData_ff;
    for (int i = 0; i < 8; i++) begin
      dmLoadPar[i] = ^dmLoadData[8*i +: 8];
    end
    dmLoadPar[0] = dmLoadPar[0] ^ ldBad;
  end
endmodule

//--- tb/tb.sv
/*
  Bench of the datapath: ops, interlock, parity event, circular addressing.
  Assumes the data memory model and the datapath package.
*/
`timescale 1ns/100ps
module tb;
  logic core_clk = 1'b0, resetn = 1'b0, ldReq, ldBad;
  logic [3:0] ldReg;
  logic [31:0] ldWord;
  logic modeWe, opReady, dmLoadValid, pmLoadValid, ubTestFlag, fetchValid, pmConflict;
  logic instrValid, instrFromCache, brValid, brTaken, predTaken, convToWord, exclLoad;
  logic exclStore, exclOk, barrierReq, busPending, barrierStall, timerEn, irqReq;
  logic [1:0] instrLen, masterErr;
  logic [3:0] dmLoadDst, pmLoadDst, storeSrc, irqIn;
  logic [7:0] dmLoadPar, irqMask, irqClr, irqPend;
  logic [23:0] fetchAddr, brPc, brTarget, predTarget;
  logic [31:0] agAddr0, agAddr1, ubValue, convIn, convOut, exclAddr, timerPeriod;
  logic [39:0] resX, resY, mulResX, mulResY;
  logic [47:0] fetchWord, instrWord;
  logic [63:0] dmLoadData, pmBusData, storeData, pxOut;
  dsp_core_pkg::mode_t modeIn;
  dsp_core_pkg::op_cmd_t opCmd;
  dsp_core_pkg::ag_cmd_t agCmd0, agCmd1;
  dsp_core_pkg::ub_cmd_t ubCmd;
  dsp_core_pkg::px_src_t pxSrc;
  typedef struct packed {dsp_core_pkg::op_kind_t kind; logic [39:0] exp;} row_t;
  row_t rows[4] = '{'{dsp_core_pkg::OP_ADD, 40'h800}, '{dsp_core_pkg::OP_SUB, 40'h200},
    '{dsp_core_pkg::OP_AND, 40'h100}, '{dsp_core_pkg::OP_XOR, 40'h600}};
  int agMod[7] = '{1, 1, 1, 1, 1, -2, -2};
  logic [31:0] agExp[7] = '{32'h100, 32'h101, 32'h102, 32'h103, 32'h100, 32'h101, 32'h103};
  int errors = 0, check_count = 0, n;
  dsp_core_datapath u_dut (.*);
  l1_data_mem_model u_mem (.*);
  always #50 core_clk = ~core_clk;
  task tick;
    @(posedge core_clk);
    #1;
  endtask
  task check(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task end_of_test;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task op(input dsp_core_pkg::op_kind_t k, input logic [3:0] d, a, b);
    opCmd = '{1'b1, k, d, 4'h6, a, b};
  endtask
  task load(input logic [3:0] r, input logic [31:0] w, input logic bad);
    ldReq = 1'b1;
    ldReg = r;
    ldWord = w;
    ldBad = bad;
    tick;
    ldReq = 1'b0;
    tick;
  endtask
  initial begin
    {modeWe, pmLoadValid, fetchValid, pmConflict, brValid, brTaken, convToWord} = '0;
    {exclLoad, exclStore, barrierReq, busPending, timerEn, masterErr, storeSrc, irqIn} = '0;
    {irqMask, irqClr, pmLoadDst, fetchAddr, fetchWord, brPc, brTarget, convIn} = '0;
    {exclAddr, timerPeriod, pmBusData, modeIn, opCmd, agCmd0, agCmd1, ubCmd} = '0;
    pxSrc = dsp_core_pkg::PX_HOLD;
    {ldReq, ldBad, ldReg, ldWord} = '0;
    repeat (6) @(posedge core_clk);
    #1 resetn = 1'b1;
    check(opReady, 1'b1);
    check(resX, 40'h0);
    $display("test reset done");
    load(4'h1, 32'h5, 1'b0);
    load(4'h2, 32'h3, 1'b0);
    check(irqPend, 8'h0);
    for (int i = 0; i < 4; i++) begin
      op(rows[i].kind, 4'h3, 4'h1, 4'h2);
      tick;
      check(resX, rows[i].exp);
    end
    op(dsp_core_pkg::OP_MAC, 4'h3, 4'h1, 4'h2);
    tick;
    check(mulResX, 40'hf0000);
    check(resX, 40'h800);
    op(dsp_core_pkg::OP_DMUL, 4'h4, 4'h1, 4'h2);
    tick;
    op(dsp_core_pkg::OP_ADD, 4'h5, 4'h4, 4'h1);
    n = 0;
    while (opReady !== 1'b1 && n < 20) begin
      n++;
      tick;
    end
    check(64'(n), 64'h5);
    if (n == 20) end_of_test;
    check(resX, 40'hf0000);
    tick;
    op(dsp_core_pkg::OP_FADD, 4'ha, 4'h1, 4'h2);
    check(resX, 40'hf0500);
    tick;
    opCmd.valid = 1'b0;
    check(resX, 40'hf0500);
    tick;
    check(resX, 40'h800);
    $display("test ops done");
    load(4'h7, 32'h12, 1'b1);
    check(irqPend[1], 1'b1);
    check(irqReq, 1'b0);
    irqMask = 8'h02;
    tick;
    check(irqReq, 1'b1);
    irqClr = 8'h02;
    tick;
    irqClr = 8'h00;
    check(irqPend[1], 1'b0);
    $display("test parity done");
    agCmd0 = '{1'b1, 1'b1, 3'h0, 32'h100, 32'h4, 32'h0};
    tick;
    for (int i = 0; i < 7; i++) begin
      agCmd0 = '{1'b1, 1'b0, 3'h0, 32'h100, 32'h4, 32'(agMod[i])};
      tick;
      check(agAddr0, agExp[i]);
    end
    agCmd0.valid = 1'b0;
    $display("test circular done");
    modeWe = 1'b1;
    modeIn = '{1'b1, 1'b0, 1'b0, 1'b0};
    tick;
    modeWe = 1'b0;
    pmLoadValid = 1'b1;
    pmLoadDst = 4'h8;
    pmBusData = 64'h9_0000_0004;
    pxSrc = dsp_core_pkg::PX_FROM_PM;
    tick;
    pmLoadValid = 1'b0;
    pxSrc = dsp_core_pkg::PX_HOLD;
    check(pxOut, 64'h9_0000_0004);
    op(dsp_core_pkg::OP_ADD, 4'h9, 4'h8, 4'h8);
    storeSrc = 4'h8;
    ubCmd = '{1'b1, 2'h1, dsp_core_pkg::UB_WRITE, 32'hf0};
    tick;
    opCmd.valid = 1'b0;
    ubCmd = '{1'b1, 2'h1, dsp_core_pkg::UB_TGL, 32'h11};
    check(resX, 40'h800);
    check(resY, 40'h1200);
    check(storeData, 64'h9_0000_0004);
    tick;
    ubCmd = '{1'b1, 2'h1, dsp_core_pkg::UB_TEST, 32'he1};
    convIn = 32'h13;
    tick;
    ubCmd.valid = 1'b0;
    check(ubValue, 32'he1);
    check(ubTestFlag, 1'b1);
    check(convOut, 32'h4c);
    $display("test simd done");
    fetchValid = 1'b1;
    pmConflict = 1'b1;
    fetchAddr = 24'h400010;
    fetchWord = 48'h8000_0000_0000;
    brValid = 1'b1;
    brPc = 24'h400010;
    brTarget = 24'h123;
    brTaken = 1'b1;
    tick;
    brValid = 1'b0;
    fetchWord = 48'h0;
    tick;
    fetchValid = 1'b0;
    check(instrFromCache, 1'b1);
    check(instrWord, 48'h8000_0000_0000);
    check(instrLen, 2'h2);
    check(predTaken, 1'b1);
    check(predTarget, 24'h123);
    $display("test fetch done");
    timerPeriod = 32'h2;
    timerEn = 1'b1;
    masterErr = 2'h1;
    exclAddr = 32'h40;
    exclLoad = 1'b1;
    tick;
    masterErr = 2'h0;
    irqClr = 8'h09;
    exclLoad = 1'b0;
    exclStore = 1'b1;
    barrierReq = 1'b1;
    busPending = 1'b1;
    check(irqPend, 8'h09);
    tick;
    irqClr = 8'h00;
    exclStore = 1'b0;
    check(exclOk, 1'b1);
    check(barrierStall, 1'b1);
    check(irqPend, 8'h00);
    tick;
    check(irqPend[0], 1'b0);
    tick;
    check(irqPend[0], 1'b1);
    $display("test events done");
    end_of_test;
  end
endmodule
